// file: verilog/pscc_defs.vh
// register indices, field positions, reset values and timing counts
`ifndef PSCC_DEFS_VH
`define PSCC_DEFS_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PSCC_IDX_PLL_STATUS   15'h7011
`define PSCC_IDX_FAST_PRESC   15'h701a
`define PSCC_IDX_SLOW_PRESC   15'h701b
`define PSCC_IDX_GATE_0       15'h701c
`define PSCC_IDX_GATE_1       15'h701d
`define PSCC_IDX_LOW_POWER    15'h701e
`define PSCC_IDX_GATE_3       15'h7020
`define PSCC_IDX_PLL_MULT     15'h7021
`define PSCC_IDX_SYS_STATUS   15'h7022
`define PSCC_IDX_WDOG_COUNT   15'h7023
`define PSCC_IDX_WDOG_KEY     15'h7025
`define PSCC_IDX_WDOG_CTRL    15'h7029
`define PSCC_IDX_PWM_REMAP    15'h702e

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define PSCC_LOCK_BIT         0
`define PSCC_PLL_OFF_BIT      2
`define PSCC_OUTPUT_DIVIDER_SELECT_LSB       7
`define PSCC_OUTPUT_DIVIDER_SELECT_MSB       8
`define PSCC_MULT_MSB         3
`define PSCC_MULT_MAX         4'ha
`define PSCC_LPM_MSB          1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PSCC_RST_WORD         16'h0000
`define PSCC_RST_MULT         4'h0
`define PSCC_RST_OUTPUT_DIVIDER_SELECT       2'h0
`define PSCC_RST_FAST_PRESC   16'h0001
`define PSCC_RST_SLOW_PRESC   16'h0002
`define PSCC_RST_LOW_POWER    16'h00fc

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PSCC_LOCK_OSC_CYCLES  131072
`define PSCC_GATE_DELAY_TICKS 2

`endif

// file: verilog/pscc_clock_control.v
// system clock control: pll ratio, output divider, gates, low power
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`include "pscc_defs.vh"

module pscc_clock_control #(
  parameter LOCK_CYCLES = `PSCC_LOCK_OSC_CYCLES
) (
  input  wire        CLOCK_I,
  input  wire        RESETN_I,
  input  wire        WATCHDOG_RESET_I,
  input  wire        SOFT_RESET_I,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [16:2] WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output wire [31:0] WB_DAT_O,
  output wire        WB_ACK_O,
  input  wire [15:0] WDOG_COUNT_I,
  input  wire        LPM_ENTER_I,
  input  wire        WAKE_PIN_I,
  output wire        CPU_CLK_TICK_O,
  output wire        SYSTEM_CLOCK_OUTPUT_O,
  output wire [47:0] PERIPH_CLK_TICK_O,
  output wire [47:0] PERIPH_CLK_EN_O,
  output wire [3:0]  CLK_MULT_O,
  output wire [2:0]  CLK_DIV_O,
  output wire        PLL_LOCK_O,
  output wire [1:0]  LOW_POWER_MODE_O,
  output wire        SLEEP_O,
  output wire [15:0] FAST_PRESC_O,
  output wire [15:0] SLOW_PRESC_O,
  output wire [15:0] WDOG_CTRL_O,
  output wire [15:0] WDOG_KEY_O,
  output wire [15:0] PWM_REMAP_O
);

  // --------------------------------------------------------------------
  // resets
  // --------------------------------------------------------------------
  wire pll_rst  = ~RESETN_I | WATCHDOG_RESET_I;
  wire misc_rst = pll_rst | SOFT_RESET_I;

  // --------------------------------------------------------------------
  // wishbone decode
  // --------------------------------------------------------------------
  reg         ack_q;
  reg  [31:0] rdat_q;
  reg  [15:0] rdat_d;
  wire        req   = WB_CYC_I & WB_STB_I & ~ack_q;
  wire        wr    = req & WB_WE_I;
  wire        wr_lo = wr & WB_SEL_I[0];
  wire        wr_hi = wr & WB_SEL_I[1];

  reg  [15:0] fast_presc_q;
  reg  [15:0] slow_presc_q;
  reg  [15:0] gate0_q;
  reg  [15:0] gate1_q;
  reg  [15:0] gate3_q;
  reg  [15:0] low_power_q;
  reg  [15:0] sys_status_q;
  reg  [15:0] wdog_key_q;
  reg  [15:0] wdog_ctrl_q;
  reg  [15:0] pwm_remap_q;
  reg  [3:0]  mult_q;
  reg  [1:0]  output_divider_select_q;
  reg         pll_off_q;
  reg         lock_q;
  reg  [17:0] lock_cnt_q;

  function [15:0] merge;
    input [15:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    begin
      merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  wire sel_pll_status = (WB_ADR_I == `PSCC_IDX_PLL_STATUS);
  wire sel_pll_mult   = (WB_ADR_I == `PSCC_IDX_PLL_MULT);

  wire [15:0] pll_status_word = {7'h00, output_divider_select_q, 4'h0, pll_off_q,
                                 1'b0, lock_q};

  always @* begin
    rdat_d = 16'h0000;
    case (WB_ADR_I)
      `PSCC_IDX_PLL_STATUS: rdat_d = pll_status_word;
      `PSCC_IDX_FAST_PRESC: rdat_d = fast_presc_q;
      `PSCC_IDX_SLOW_PRESC: rdat_d = slow_presc_q;
      `PSCC_IDX_GATE_0:     rdat_d = gate0_q;
      `PSCC_IDX_GATE_1:     rdat_d = gate1_q;
      `PSCC_IDX_LOW_POWER:  rdat_d = low_power_q;
      `PSCC_IDX_GATE_3:     rdat_d = gate3_q;
      `PSCC_IDX_PLL_MULT:   rdat_d = {12'h000, mult_q};
      `PSCC_IDX_SYS_STATUS: rdat_d = sys_status_q;
      `PSCC_IDX_WDOG_COUNT: rdat_d = WDOG_COUNT_I;
      `PSCC_IDX_WDOG_KEY:   rdat_d = wdog_key_q;
      `PSCC_IDX_WDOG_CTRL:  rdat_d = wdog_ctrl_q;
      `PSCC_IDX_PWM_REMAP:  rdat_d = pwm_remap_q;
      default:              rdat_d = 16'h0000;
    endcase
  end

  always @(posedge CLOCK_I) begin
    if (~RESETN_I) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      rdat_q <= req ? {16'h0000, rdat_d} : 32'h0000_0000;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // --------------------------------------------------------------------
  // pll registers, lock counter
  // --------------------------------------------------------------------
  wire [3:0] mult_wr  = WB_DAT_I[`PSCC_MULT_MSB:0];
  wire       mult_ok  = (mult_wr <= `PSCC_MULT_MAX);
  wire       mult_we  = wr_lo & sel_pll_mult & mult_ok;

  always @(posedge CLOCK_I) begin
    if (pll_rst) begin
      mult_q     <= `PSCC_RST_MULT;
      output_divider_select_q   <= `PSCC_RST_OUTPUT_DIVIDER_SELECT;
      pll_off_q  <= 1'b0;
      lock_q     <= 1'b0;
      lock_cnt_q <= 18'h0_0000;
    end else begin
      if (wr_lo & sel_pll_status) begin
        pll_off_q <= WB_DAT_I[`PSCC_PLL_OFF_BIT];
      end
      if (wr & sel_pll_status & WB_SEL_I[0] & WB_SEL_I[1]) begin
        output_divider_select_q <= WB_DAT_I[`PSCC_OUTPUT_DIVIDER_SELECT_MSB:`PSCC_OUTPUT_DIVIDER_SELECT_LSB];
      end
      if (mult_we) begin
        // drop to bypass, restart lock wait
        mult_q     <= mult_wr;
        lock_q     <= 1'b0;
        lock_cnt_q <= 18'h0_0000;
      end else if (~lock_q) begin
        if (lock_cnt_q == LOCK_CYCLES[17:0] - 18'h0_0001) begin
          lock_q <= 1'b1;
        end else begin
          lock_cnt_q <= lock_cnt_q + 18'h0_0001;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // other registers
  // --------------------------------------------------------------------
  always @(posedge CLOCK_I) begin
    if (misc_rst) begin
      fast_presc_q <= `PSCC_RST_FAST_PRESC;
      slow_presc_q <= `PSCC_RST_SLOW_PRESC;
      gate0_q      <= `PSCC_RST_WORD;
      gate1_q      <= `PSCC_RST_WORD;
      gate3_q      <= `PSCC_RST_WORD;
      low_power_q  <= `PSCC_RST_LOW_POWER;
      sys_status_q <= `PSCC_RST_WORD;
      wdog_key_q   <= `PSCC_RST_WORD;
      wdog_ctrl_q  <= `PSCC_RST_WORD;
      pwm_remap_q  <= `PSCC_RST_WORD;
    end else if (wr_lo | wr_hi) begin
      case (WB_ADR_I)
        `PSCC_IDX_FAST_PRESC:
          fast_presc_q <= merge(fast_presc_q, WB_DAT_I, WB_SEL_I);
        `PSCC_IDX_SLOW_PRESC:
          slow_presc_q <= merge(slow_presc_q, WB_DAT_I, WB_SEL_I);
        `PSCC_IDX_GATE_0:
          gate0_q <= merge(gate0_q, WB_DAT_I, WB_SEL_I);
        `PSCC_IDX_GATE_1:
          gate1_q <= merge(gate1_q, WB_DAT_I, WB_SEL_I);
        `PSCC_IDX_GATE_3:
          gate3_q <= merge(gate3_q, WB_DAT_I, WB_SEL_I);
        `PSCC_IDX_LOW_POWER:
          low_power_q <= merge(low_power_q, WB_DAT_I, WB_SEL_I);
        `PSCC_IDX_SYS_STATUS:
          sys_status_q <= merge(sys_status_q, WB_DAT_I, WB_SEL_I);
        `PSCC_IDX_WDOG_KEY:
          wdog_key_q <= merge(wdog_key_q, WB_DAT_I, WB_SEL_I);
        `PSCC_IDX_WDOG_CTRL:
          wdog_ctrl_q <= merge(wdog_ctrl_q, WB_DAT_I, WB_SEL_I);
        `PSCC_IDX_PWM_REMAP:
          pwm_remap_q <= merge(pwm_remap_q, WB_DAT_I, WB_SEL_I);
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // ratio select
  // --------------------------------------------------------------------
  reg  [3:0] num_sel;
  reg  [2:0] den_sel;
  wire       pll_used = lock_q & ~pll_off_q & (mult_q != 4'h0);

  always @* begin
    num_sel = pll_used ? mult_q : 4'h1;
    case (output_divider_select_q)
      2'h2:    den_sel = 3'h2;
      2'h3:    den_sel = 3'h1;
      default: den_sel = 3'h4;
    endcase
  end

  // --------------------------------------------------------------------
  // tick generator
  // --------------------------------------------------------------------
  reg  [3:0] num_q;
  reg  [2:0] den_q;
  reg  [3:0] acc_q;
  reg  [3:0] acc_d;
  wire [4:0] sum   = {1'b0, acc_q} + {1'b0, num_q};
  wire       tick  = (sum >= {2'b00, den_q});
  wire [4:0] rem   = sum - {2'b00, den_q};

  always @* begin
    acc_d = acc_q;
    if (tick) begin
      if (rem >= {2'b00, den_q}) begin
        acc_d = {1'b0, den_q} - 4'h1;
      end else begin
        acc_d = rem[3:0];
      end
    end else begin
      acc_d = sum[3:0];
    end
  end

  always @(posedge CLOCK_I) begin
    if (pll_rst) begin
      num_q <= 4'h1;
      den_q <= 3'h4;
      acc_q <= 4'h0;
    end else begin
      acc_q <= acc_d;
      if (tick) begin
        // new ratio taken only at a tick boundary
        num_q <= num_sel;
        den_q <= den_sel;
      end
    end
  end

  // --------------------------------------------------------------------
  // low power
  // --------------------------------------------------------------------
  reg  wake_s1_q;
  reg  wake_s2_q;
  reg  sleep_q;
  wire deep_mode = (low_power_q[`PSCC_LPM_MSB:0] != 2'h0);

  always @(posedge CLOCK_I) begin
    if (misc_rst) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      sleep_q   <= 1'b0;
    end else begin
      wake_s1_q <= WAKE_PIN_I;
      wake_s2_q <= wake_s1_q;
      if (wake_s2_q) begin
        sleep_q <= 1'b0;
      end else if (LPM_ENTER_I & deep_mode) begin
        sleep_q <= 1'b1;
      end
    end
  end

  // one tick drives cpu and system output
  wire sys_tick = tick & ~sleep_q;

  // --------------------------------------------------------------------
  // peripheral gates
  // --------------------------------------------------------------------
  reg  [47:0] gate_s1_q;
  reg  [47:0] gate_s2_q;

  always @(posedge CLOCK_I) begin
    if (misc_rst) begin
      gate_s1_q <= 48'h0000_0000_0000;
      gate_s2_q <= 48'h0000_0000_0000;
    end else if (sys_tick) begin
      gate_s1_q <= {gate3_q, gate1_q, gate0_q};
      gate_s2_q <= gate_s1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 48; g = g + 1) begin : gen_gate
      assign PERIPH_CLK_TICK_O[g] = sys_tick & gate_s2_q[g];
    end
  endgenerate

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign CPU_CLK_TICK_O        = sys_tick;
  assign SYSTEM_CLOCK_OUTPUT_O = sys_tick;
  assign PERIPH_CLK_EN_O       = gate_s2_q;
  assign CLK_MULT_O            = num_q;
  assign CLK_DIV_O             = den_q;
  assign PLL_LOCK_O            = lock_q;
  assign LOW_POWER_MODE_O      = low_power_q[`PSCC_LPM_MSB:0];
  assign SLEEP_O               = sleep_q;
  assign FAST_PRESC_O          = fast_presc_q;
  assign SLOW_PRESC_O          = slow_presc_q;
  assign WDOG_CTRL_O           = wdog_ctrl_q;
  assign WDOG_KEY_O            = wdog_key_q;
  assign PWM_REMAP_O           = pwm_remap_q;

endmodule

// file: tb/pscc_clock_control_properties.sv
// concurrent checks on the clock control ports
`timescale 1ns/100ps
module pscc_clock_control_props #(
  parameter LOCK_CYCLES = 16
) (
  input wire        CLOCK_I,
  input wire        RESETN_I,
  input wire        WATCHDOG_RESET_I,
  input wire        SOFT_RESET_I,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_ACK_O,
  input wire        CPU_CLK_TICK_O,
  input wire        SYSTEM_CLOCK_OUTPUT_O,
  input wire [47:0] PERIPH_CLK_TICK_O,
  input wire [47:0] PERIPH_CLK_EN_O,
  input wire [3:0]  CLK_MULT_O,
  input wire [2:0]  CLK_DIV_O,
  input wire        PLL_LOCK_O,
  input wire        SLEEP_O
);
  // ----------------------------------------------------------------
  // unlocked cycle count
  // ----------------------------------------------------------------
  int lo_cnt_q;
  always @(posedge CLOCK_I) begin
    if (!RESETN_I || WATCHDOG_RESET_I || PLL_LOCK_O)
      lo_cnt_q <= 0;
    else
      lo_cnt_q <= lo_cnt_q + 1;
  end
  default clocking dc @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I || WATCHDOG_RESET_I);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held past one cycle");
  a_ack_answer: assert property
    (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_sysclk_same: assert property
    (SYSTEM_CLOCK_OUTPUT_O == CPU_CLK_TICK_O)
    else $error("system clock output differs from cpu tick");
  a_div_legal: assert property (CLK_DIV_O inside {3'h1, 3'h2, 3'h4})
    else $error("divisor out of set");
  a_mult_range: assert property (CLK_MULT_O inside {[4'h1:4'ha]})
    else $error("multiplier out of range");
  a_bypass_hold: assert property
    (!PLL_LOCK_O && CPU_CLK_TICK_O |=> CLK_MULT_O == 4'h1)
    else $error("multiplied clock before lock");
  a_gate_and: assert property
    (PERIPH_CLK_TICK_O == ({48{CPU_CLK_TICK_O}} & PERIPH_CLK_EN_O))
    else $error("peripheral tick not gated cpu tick");
  a_gate_edge: assert property
    (!$stable(PERIPH_CLK_EN_O) |-> $past(CPU_CLK_TICK_O || SOFT_RESET_I))
    else $error("gate applied off a tick edge");
  a_lock_time: assert property
    ($rose(PLL_LOCK_O) |-> lo_cnt_q >= LOCK_CYCLES - 1)
    else $error("lock came early");
  a_lock_bound: assert property (lo_cnt_q <= LOCK_CYCLES + 1)
    else $error("lock came late");
  a_sleep_quiet: assert property
    (SLEEP_O |-> !CPU_CLK_TICK_O && PERIPH_CLK_TICK_O == 48'h0000_0000_0000)
    else $error("ticks while asleep");
endmodule
bind pscc_clock_control pscc_clock_control_props #(
  .LOCK_CYCLES(LOCK_CYCLES)
) u_props (
  .CLOCK_I              (CLOCK_I),
  .RESETN_I             (RESETN_I),
  .WATCHDOG_RESET_I     (WATCHDOG_RESET_I),
  .SOFT_RESET_I         (SOFT_RESET_I),
  .WB_CYC_I             (WB_CYC_I),
  .WB_STB_I             (WB_STB_I),
  .WB_ACK_O             (WB_ACK_O),
  .CPU_CLK_TICK_O       (CPU_CLK_TICK_O),
  .SYSTEM_CLOCK_OUTPUT_O(SYSTEM_CLOCK_OUTPUT_O),
  .PERIPH_CLK_TICK_O    (PERIPH_CLK_TICK_O),
  .PERIPH_CLK_EN_O      (PERIPH_CLK_EN_O),
  .CLK_MULT_O           (CLK_MULT_O),
  .CLK_DIV_O            (CLK_DIV_O),
  .PLL_LOCK_O           (PLL_LOCK_O),
  .SLEEP_O              (SLEEP_O)
);

// file: tb/pscc_clock_control_test.sv
// self-checking bench for the clock control block
`timescale 1ns/100ps
`include "pscc_defs.vh"
module pscc_clock_control_test;
  localparam int LOCK = 16;
  logic        CLOCK_I, RESETN_I, WATCHDOG_RESET_I, SOFT_RESET_I;
  logic        WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, PLL_LOCK_O, SLEEP_O;
  logic        LPM_ENTER_I, WAKE_PIN_I, CPU_CLK_TICK_O, SYSTEM_CLOCK_OUTPUT_O;
  logic [14:0] WB_ADR_I;
  logic [3:0]  WB_SEL_I, CLK_MULT_O;
  logic [31:0] WB_DAT_I, WB_DAT_O;
  logic [15:0] WDOG_COUNT_I, FAST_PRESC_O, SLOW_PRESC_O, WDOG_CTRL_O;
  logic [15:0] WDOG_KEY_O, PWM_REMAP_O;
  logic [47:0] PERIPH_CLK_TICK_O, PERIPH_CLK_EN_O;
  logic [2:0]  CLK_DIV_O;
  logic [1:0]  LOW_POWER_MODE_O;
  int          miscompares = 0, compares = 0, tick_n = 0, mark = 0;
  int          i, n, t0;
  int          dv [4] = '{4, 4, 2, 1};
  logic [14:0] ra [8] = '{`PSCC_IDX_FAST_PRESC, `PSCC_IDX_SLOW_PRESC,
    `PSCC_IDX_WDOG_CTRL, `PSCC_IDX_WDOG_KEY, `PSCC_IDX_PWM_REMAP,
    `PSCC_IDX_WDOG_COUNT, 15'h7012, `PSCC_IDX_GATE_1};
  logic [15:0] rw [8] = '{16'h0005, 16'h0003, 16'h0068, 16'h00aa,
    16'h0001, 16'h1234, 16'hffff, 16'h00ff};
  logic [15:0] re [8] = '{16'h0005, 16'h0003, 16'h0068, 16'h00aa,
    16'h0001, 16'h0a5a, 16'h0000, 16'h00ff};
  pscc_clock_control #(
    .LOCK_CYCLES(LOCK)
  ) dut (
    .CLOCK_I              (CLOCK_I),
    .RESETN_I             (RESETN_I),
    .WATCHDOG_RESET_I     (WATCHDOG_RESET_I),
    .SOFT_RESET_I         (SOFT_RESET_I),
    .WB_CYC_I             (WB_CYC_I),
    .WB_STB_I             (WB_STB_I),
    .WB_WE_I              (WB_WE_I),
    .WB_ADR_I             (WB_ADR_I),
    .WB_SEL_I             (WB_SEL_I),
    .WB_DAT_I             (WB_DAT_I),
    .WB_DAT_O             (WB_DAT_O),
    .WB_ACK_O             (WB_ACK_O),
    .WDOG_COUNT_I         (WDOG_COUNT_I),
    .LPM_ENTER_I          (LPM_ENTER_I),
    .WAKE_PIN_I           (WAKE_PIN_I),
    .CPU_CLK_TICK_O       (CPU_CLK_TICK_O),
    .SYSTEM_CLOCK_OUTPUT_O(SYSTEM_CLOCK_OUTPUT_O),
    .PERIPH_CLK_TICK_O    (PERIPH_CLK_TICK_O),
    .PERIPH_CLK_EN_O      (PERIPH_CLK_EN_O),
    .CLK_MULT_O           (CLK_MULT_O),
    .CLK_DIV_O            (CLK_DIV_O),
    .PLL_LOCK_O           (PLL_LOCK_O),
    .LOW_POWER_MODE_O     (LOW_POWER_MODE_O),
    .SLEEP_O              (SLEEP_O),
    .FAST_PRESC_O         (FAST_PRESC_O),
    .SLOW_PRESC_O         (SLOW_PRESC_O),
    .WDOG_CTRL_O          (WDOG_CTRL_O),
    .WDOG_KEY_O           (WDOG_KEY_O),
    .PWM_REMAP_O          (PWM_REMAP_O)
  );
  // ----------------------------------------------------------------
  // clock, tick count and gate write mark
  // ----------------------------------------------------------------
  initial begin
    CLOCK_I = 1'b0;
    forever #12.5 CLOCK_I = ~CLOCK_I;
  end
  always @(posedge CLOCK_I) begin
    tick_n <= tick_n + CPU_CLK_TICK_O;
    if (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O &&
        WB_ADR_I == `PSCC_IDX_GATE_0)
      mark <= tick_n + CPU_CLK_TICK_O;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task test_done;
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task bound(input int k);
    if (k >= 60) begin
      miscompares++;
      $display("[FAIL] wait loop exp <60 got %0d", k);
      test_done;
    end
  endtask
  task wb(input logic w, input logic [14:0] a, input logic [15:0] d,
          output logic [15:0] q);
    int k;
    @(posedge CLOCK_I);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= {16'h0000, d};
    for (k = 0; k < 60; k++) begin
      @(posedge CLOCK_I);
      if (WB_ACK_O === 1'b1) break;
    end
    q = WB_DAT_O[15:0];
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    bound(k);
  endtask
  task wr(input logic [14:0] a, input logic [15:0] d);
    logic [15:0] x;
    wb(1'b1, a, d, x);
  endtask
  task rd(input string nm, input logic [14:0] a, input logic [15:0] e);
    logic [15:0] x;
    wb(1'b0, a, 16'h0000, x);
    cmp(nm, 32'(e), 32'(x));
  endtask
  task wait_tick;
    int k;
    for (k = 0; k < 60; k++) begin
      @(posedge CLOCK_I);
      if (CPU_CLK_TICK_O === 1'b1) break;
    end
    #1;
    bound(k);
  endtask
  task rate(input string nm, input int e);
    t0 = tick_n;
    repeat (40) @(posedge CLOCK_I);
    #1 cmp(nm, 32'(e), 32'(tick_n - t0));
  endtask
  initial begin
    repeat (20000) @(posedge CLOCK_I);
    miscompares++;
    test_done;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {RESETN_I, WATCHDOG_RESET_I, SOFT_RESET_I, LPM_ENTER_I} = 4'h0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, WAKE_PIN_I} = 4'h0;
    WB_ADR_I = 15'h0000;
    WB_SEL_I = 4'h3;
    WB_DAT_I = 32'h0000_0000;
    WDOG_COUNT_I = 16'h0a5a;
    repeat (3) @(posedge CLOCK_I);
    RESETN_I <= 1'b1;
    for (n = 0; n < 8; n++) begin
      wr(ra[n], rw[n]);
      rd("register row", ra[n], re[n]);
    end
    cmp("slow out", 32'h0000_0003, 32'(SLOW_PRESC_O));
    cmp("key out", 32'h0000_00aa, 32'(WDOG_KEY_O));
    cmp("remap out", 32'h0000_0001, 32'(PWM_REMAP_O));
    wr(`PSCC_IDX_GATE_0, 16'h0001);
    for (i = 0; i < 60 && PERIPH_CLK_EN_O[0] !== 1'b1; i++) begin
      @(posedge CLOCK_I);
      #1;
    end
    bound(i);
    cmp("gate delay", 32'h0000_0002, 32'(tick_n - mark));
    wr(`PSCC_IDX_WDOG_CTRL, 16'h0068);
    cmp("wdog ctrl out", 32'h0000_0068, 32'(WDOG_CTRL_O));
    for (n = 1; n <= 7; n++) begin
      wr(`PSCC_IDX_PLL_MULT, 16'(n));
      wait_tick;
      cmp("bypass mult", 32'h0000_0001, 32'(CLK_MULT_O));
      cmp("lock low", 32'h0000_0000, 32'(PLL_LOCK_O));
      for (i = 0; i < 60 && PLL_LOCK_O !== 1'b1; i++) begin
        @(posedge CLOCK_I);
        #1;
      end
      bound(i);
      wait_tick;
      cmp("mult", 32'(n), 32'(CLK_MULT_O));
      rate("mult rate", n < 4 ? 10 * n : 40);
    end
    wr(`PSCC_IDX_PLL_MULT, 16'h000b);
    rd("reserved mult", `PSCC_IDX_PLL_MULT, 16'h0007);
    wr(`PSCC_IDX_FAST_PRESC, 16'h0007);
    @(posedge CLOCK_I) SOFT_RESET_I <= 1'b1;
    repeat (3) @(posedge CLOCK_I);
    SOFT_RESET_I <= 1'b0;
    rd("soft mult", `PSCC_IDX_PLL_MULT, 16'h0007);
    rd("soft presc", `PSCC_IDX_FAST_PRESC, 16'h0001);
    cmp("soft lock", 32'h0000_0001, 32'(PLL_LOCK_O));
    @(posedge CLOCK_I) WATCHDOG_RESET_I <= 1'b1;
    repeat (3) @(posedge CLOCK_I);
    WATCHDOG_RESET_I <= 1'b0;
    rd("wdog mult", `PSCC_IDX_PLL_MULT, 16'h0000);
    for (i = 0; i < 60 && PLL_LOCK_O !== 1'b1; i++) @(posedge CLOCK_I);
    bound(i);
    for (n = 0; n < 4; n++) begin
      wr(`PSCC_IDX_PLL_STATUS, 16'(n << 7));
      wait_tick;
      cmp("divisor", 32'(dv[n]), 32'(CLK_DIV_O));
      rate("div rate", 40 / dv[n]);
    end
    rd("status", `PSCC_IDX_PLL_STATUS, 16'h0181);
    wr(`PSCC_IDX_PLL_STATUS, 16'h0000);
    wr(`PSCC_IDX_LOW_POWER, 16'h0001);
    cmp("lpm", 32'h0000_0001, 32'(LOW_POWER_MODE_O));
    @(posedge CLOCK_I) LPM_ENTER_I <= 1'b1;
    @(posedge CLOCK_I) LPM_ENTER_I <= 1'b0;
    for (i = 0; i < 60 && SLEEP_O !== 1'b1; i++) @(posedge CLOCK_I);
    bound(i);
    t0 = tick_n;
    repeat (20) @(posedge CLOCK_I);
    #1 cmp("sleep ticks", 32'h0000_0000, 32'(tick_n - t0));
    @(posedge CLOCK_I) WAKE_PIN_I <= 1'b1;
    for (i = 0; i < 60 && SLEEP_O !== 1'b0; i++) @(posedge CLOCK_I);
    bound(i);
    WAKE_PIN_I <= 1'b0;
    @(posedge CLOCK_I) RESETN_I <= 1'b0;
    repeat (3) @(posedge CLOCK_I);
    RESETN_I <= 1'b1;
    rd("rst status", `PSCC_IDX_PLL_STATUS, 16'h0000);
    rd("rst fast", `PSCC_IDX_FAST_PRESC, 16'h0001);
    rd("rst slow", `PSCC_IDX_SLOW_PRESC, 16'h0002);
    rd("rst lpm", `PSCC_IDX_LOW_POWER, 16'h00fc);
    rd("rst gate", `PSCC_IDX_GATE_0, 16'h0000);
    cmp("rst fast out", 32'h0000_0001, 32'(FAST_PRESC_O));
    test_done;
  end
endmodule
